// file: pkg/sfti_pkg.sv
package sfti_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [7:0] SFTI_FLAGS_IDX = 8'h0a;
    localparam logic [7:0] SFTI_IRQC_IDX = 8'h0b;
    localparam logic [7:0] SFTI_STATE_IDX = 8'h0c;

    // Flag register fields
    localparam int SFTI_C_BIT = 0;
    localparam int SFTI_NIB_CARRY_BIT = 1;
    localparam int SFTI_Z_BIT = 2;
    localparam int SFTI_WRAP_BIT = 3;
    localparam int SFTI_PWR_DOWN_BIT = 4;
    localparam int SFTI_EXPIRY_BIT = 5;
    localparam logic [7:0] SFTI_FLAGS_WMASK = 8'h0f;
    localparam logic [7:0] SFTI_FLAGS_RST = 8'h00;

    // Interrupt control fields
    localparam int SFTI_GIE_BIT = 0;
    localparam int SFTI_T0_EN_BIT = 2;
    localparam int SFTI_T1_EN_BIT = 3;
    localparam int SFTI_T0_REQ_BIT = 5;
    localparam int SFTI_T1_REQ_BIT = 6;

    // Interrupt vectors
    localparam logic [7:0] SFTI_VEC_T0 = 8'h08;
    localparam logic [7:0] SFTI_VEC_T1 = 8'h0c;

    // Return stack
    localparam int SFTI_PC_W = 13;
    localparam int SFTI_STACK_DEPTH = 8;
    localparam logic [3:0] SFTI_STACK_FULL = 4'h8;

    typedef enum logic [2:0] {
        SFTI_OP_ADD,
        SFTI_OP_ADC,
        SFTI_OP_SUB,
        SFTI_OP_SBC,
        SFTI_OP_LOGIC,
        SFTI_OP_RLC,
        SFTI_OP_RRC,
        SFTI_OP_INCDEC
    } sfti_alu_op_e;

    typedef enum logic [1:0] {
        SFTI_SEL_NONE,
        SFTI_SEL_FLAGS,
        SFTI_SEL_IRQC,
        SFTI_SEL_STATE
    } sfti_sel_e;

endpackage

// file: hw/sfti_req_flag.sv
module sfti_req_flag import sfti_pkg::*; #(
    parameter logic RST_VAL = 1'b0
) (
    input logic hclk,
    input logic hresetn,
    input logic evt,
    input logic sw_wr,
    input logic sw_val,
    input logic svc_clr,
    output logic flag
);

    typedef struct packed {
        logic flag;
    } sfti_flag_s;

    sfti_flag_s s_q;
    sfti_flag_s s_d;

    always_comb begin
        s_d = s_q;
        if (sw_wr) begin
            s_d.flag = sw_val;
        end
        if (svc_clr) begin
            s_d.flag = 1'b0;
        end
        // Event wins over any clear
        if (evt) begin
            s_d.flag = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.flag <= RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;

    chk_flag_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        evt |=> flag)
        else $error("request flag lost an event");

    chk_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (flag && !sw_wr && !svc_clr) |=> flag)
        else $error("request flag dropped without service");

endmodule

// file: hw/sfti_core.sv
// Behaviour
// - Carry from add, no-borrow from sub, rotates
// - Nibble carry from low nibble
// - Zero flag follows zero result; rotates leave it
// - Wrap flag: carry into msb xor out
// - Halt sets power-down; watchdog clear clears
// - Timeout sets expiry; clear or halt clears
// - Bus writes leave power-down, expiry untouched
// - Flags never pushed onto return stack
// - Acknowledge pushes PC then branches vector
// - Acknowledge clears global enable
// - Blocked requests still set their flags
// - Re-enabling inside service permits nesting
// - Full stack blocks acknowledge until return
// - Timer0 flag bit 5, vector 08H
// - Timer1 enable bit 3, flag 6, vector 0CH
// - Return-with-reenable sets global enable
// - Requests serviced on phase two pulse
// - Timer0 before timer1; global enable masks
// - Request flags held until serviced/cleared
// - Control bit 0 is global enable
// - Control bit 2 enables timer0
// - Any source wakes from halt
// - Eight-level stack, full at eight
//
// Design decision made here: the AHB-Lite interface to the registers.
module sfti_core import sfti_pkg::*; (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input logic alu_valid,
    input sfti_alu_op_e alu_op,
    input logic [7:0] alu_a,
    input logic [7:0] alu_b,
    output logic [7:0] alu_result,
    input logic halt_instr,
    input logic watchdog_clear_instr,
    input logic watchdog_timeout,
    input logic call_instr,
    input logic return_instr,
    input logic return_with_irq_reenable,
    input logic [SFTI_PC_W-1:0] pc_current,
    input logic phase_two_pulse,
    input logic timer0_overflow,
    input logic timer1_overflow,
    output logic irq_ack,
    output logic [7:0] irq_vector,
    output logic [SFTI_PC_W-1:0] return_pc,
    output logic stack_full,
    output logic [2:0] stack_index,
    output logic halted
);

    typedef struct packed {
        logic [7:0] flags;
        logic gie;
        logic t0_en;
        logic t1_en;
        logic [SFTI_STACK_DEPTH-1:0][SFTI_PC_W-1:0] stk;
        logic [2:0] sidx;
        logic [3:0] depth;
        logic halted;
        logic [7:0] alu_res;
        logic ack;
        logic [7:0] vec;
        logic [SFTI_PC_W-1:0] ret_pc;
        logic full;
        logic wr_pend;
        sfti_sel_e wr_sel;
        logic [31:0] rdata;
        logic rdy;
    } sfti_core_s;

    sfti_core_s s_q;
    sfti_core_s s_d;

    logic t0_req;
    logic t1_req;
    logic ack0;
    logic ack1;
    logic sw_irqc_wr;
    logic [7:0] bb;
    logic ci;
    logic is_sub;
    logic [8:0] s9;
    logic [4:0] lo5;
    logic [7:0] s7;
    logic [7:0] res;
    logic [7:0] rv;
    logic addr_ok;
    logic pend0;
    logic pend1;
    logic stack_op;
    logic take;
    sfti_sel_e sel;

    // Data phase write to the control register feeds the request flags
    assign sw_irqc_wr = s_q.wr_pend && (s_q.wr_sel == SFTI_SEL_IRQC);

    sfti_req_flag #(
        .RST_VAL(1'b0)
    ) u_t0_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .evt(timer0_overflow),
        .sw_wr(sw_irqc_wr),
        .sw_val(hwdata[SFTI_T0_REQ_BIT]),
        .svc_clr(ack0),
        .flag(t0_req)
    );

    sfti_req_flag #(
        .RST_VAL(1'b0)
    ) u_t1_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .evt(timer1_overflow),
        .sw_wr(sw_irqc_wr),
        .sw_val(hwdata[SFTI_T1_REQ_BIT]),
        .svc_clr(ack1),
        .flag(t1_req)
    );

    always_comb begin
        bb = 8'h00;
        ci = 1'b0;
        is_sub = 1'b0;
        s9 = 9'h000;
        lo5 = 5'h00;
        s7 = 8'h00;
        res = 8'h00;
        rv = 8'h00;
        addr_ok = 1'b0;
        pend0 = 1'b0;
        pend1 = 1'b0;
        stack_op = 1'b0;
        take = 1'b0;
        ack0 = 1'b0;
        ack1 = 1'b0;
        sel = SFTI_SEL_NONE;
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.rdy = 1'b1;

        // Adder shared by add and subtract forms
        is_sub = (alu_op == SFTI_OP_SUB) || (alu_op == SFTI_OP_SBC);
        bb = is_sub ? ~alu_b : alu_b;
        unique case (alu_op)
            SFTI_OP_ADC, SFTI_OP_SBC: ci = s_q.flags[SFTI_C_BIT];
            SFTI_OP_SUB: ci = 1'b1;
            default: ci = 1'b0;
        endcase
        s9 = {1'b0, alu_a} + {1'b0, bb} + {8'h00, ci};
        lo5 = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        s7 = {1'b0, alu_a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};

        if (alu_valid) begin
            unique case (alu_op)
                SFTI_OP_ADD, SFTI_OP_ADC, SFTI_OP_SUB, SFTI_OP_SBC: begin
                    res = s9[7:0];
                    s_d.flags[SFTI_C_BIT] = s9[8];
                    s_d.flags[SFTI_NIB_CARRY_BIT] = lo5[4];
                    s_d.flags[SFTI_Z_BIT] = (s9[7:0] == 8'h00);
                    s_d.flags[SFTI_WRAP_BIT] = s7[7] ^ s9[8];
                end
                SFTI_OP_LOGIC, SFTI_OP_INCDEC: begin
                    res = alu_b;
                    s_d.flags[SFTI_Z_BIT] = (alu_b == 8'h00);
                end
                SFTI_OP_RLC: begin
                    res = {alu_a[6:0], s_q.flags[SFTI_C_BIT]};
                    s_d.flags[SFTI_C_BIT] = alu_a[7];
                end
                SFTI_OP_RRC: begin
                    res = {s_q.flags[SFTI_C_BIT], alu_a[7:1]};
                    s_d.flags[SFTI_C_BIT] = alu_a[0];
                end
            endcase
            s_d.alu_res = res;
        end

        // Bus data phase
        if (s_q.wr_pend) begin
            unique case (s_q.wr_sel)
                SFTI_SEL_FLAGS: begin
                    s_d.flags = (s_q.flags & ~SFTI_FLAGS_WMASK)
                        | (hwdata[7:0] & SFTI_FLAGS_WMASK);
                end
                SFTI_SEL_IRQC: begin
                    s_d.gie = hwdata[SFTI_GIE_BIT];
                    s_d.t0_en = hwdata[SFTI_T0_EN_BIT];
                    s_d.t1_en = hwdata[SFTI_T1_EN_BIT];
                end
                default: begin
                end
            endcase
        end

        // Power-down and expiry flags
        if (watchdog_clear_instr) begin
            s_d.flags[SFTI_PWR_DOWN_BIT] = 1'b0;
            s_d.flags[SFTI_EXPIRY_BIT] = 1'b0;
        end
        if (halt_instr) begin
            s_d.flags[SFTI_PWR_DOWN_BIT] = 1'b1;
            s_d.flags[SFTI_EXPIRY_BIT] = 1'b0;
        end
        if (watchdog_timeout) begin
            s_d.flags[SFTI_EXPIRY_BIT] = 1'b1;
        end

        // Halt and wake
        if (halt_instr) begin
            s_d.halted = 1'b1;
        end else if (timer0_overflow || timer1_overflow || watchdog_timeout) begin
            s_d.halted = 1'b0;
        end

        // Return stack, program counter only
        stack_op = call_instr || return_instr || return_with_irq_reenable;
        if (call_instr) begin
            s_d.stk[s_q.sidx] = pc_current;
            s_d.sidx = s_q.sidx + 3'd1;
            if (s_q.depth != SFTI_STACK_FULL) begin
                s_d.depth = s_q.depth + 4'd1;
            end
        end else if (return_instr || return_with_irq_reenable) begin
            s_d.sidx = s_q.sidx - 3'd1;
            s_d.ret_pc = s_q.stk[s_q.sidx - 3'd1];
            if (s_q.depth != 4'h0) begin
                s_d.depth = s_q.depth - 4'd1;
            end
            if (return_with_irq_reenable) begin
                s_d.gie = 1'b1;
            end
        end

        // Interrupt acknowledge on the phase two pulse
        pend0 = s_q.gie && s_q.t0_en && t0_req;
        pend1 = s_q.gie && s_q.t1_en && t1_req;
        take = phase_two_pulse && (pend0 || pend1) && (s_q.depth != SFTI_STACK_FULL)
            && !s_q.halted && !stack_op;
        if (take) begin
            ack0 = pend0;
            ack1 = !pend0;
            s_d.ack = 1'b1;
            s_d.vec = pend0 ? SFTI_VEC_T0 : SFTI_VEC_T1;
            s_d.stk[s_q.sidx] = pc_current;
            s_d.sidx = s_q.sidx + 3'd1;
            s_d.depth = s_q.depth + 4'd1;
            s_d.gie = 1'b0;
        end
        s_d.full = (s_d.depth == SFTI_STACK_FULL);

        // Bus address phase
        s_d.wr_pend = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (hsel && htrans[1] && hready) begin
            addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);
            if (addr_ok && (haddr[9:2] == SFTI_FLAGS_IDX)) begin
                sel = SFTI_SEL_FLAGS;
            end else if (addr_ok && (haddr[9:2] == SFTI_IRQC_IDX)) begin
                sel = SFTI_SEL_IRQC;
            end else if (addr_ok && (haddr[9:2] == SFTI_STATE_IDX)) begin
                sel = SFTI_SEL_STATE;
            end
            unique case (sel)
                SFTI_SEL_FLAGS: rv = s_q.flags;
                SFTI_SEL_IRQC: begin
                    rv[SFTI_GIE_BIT] = s_q.gie;
                    rv[SFTI_T0_EN_BIT] = s_q.t0_en;
                    rv[SFTI_T1_EN_BIT] = s_q.t1_en;
                    rv[SFTI_T0_REQ_BIT] = t0_req;
                    rv[SFTI_T1_REQ_BIT] = t1_req;
                end
                SFTI_SEL_STATE: rv = {3'b000, s_q.halted, s_q.depth};
                default: rv = 8'h00;
            endcase
            s_d.wr_pend = hwrite;
            s_d.wr_sel = sel;
            if (!hwrite) begin
                s_d.rdata = {24'h000000, rv};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.rdy;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign alu_result = s_q.alu_res;
    assign irq_ack = s_q.ack;
    assign irq_vector = s_q.vec;
    assign return_pc = s_q.ret_pc;
    assign stack_full = s_q.full;
    assign stack_index = s_q.sidx;
    assign halted = s_q.halted;

    chk_t0_vector: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase_two_pulse && s_q.gie && s_q.t0_en && t0_req && !s_q.full && !s_q.halted
            && !stack_op && !timer0_overflow)
            |=> (irq_ack && irq_vector == SFTI_VEC_T0 && !t0_req))
        else $error("timer0 request not vectored");

    chk_t1_second: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase_two_pulse && s_q.gie && s_q.t1_en && t1_req && t0_req && s_q.t0_en
            && !s_q.full && !s_q.halted && !stack_op && !timer1_overflow)
            |=> (irq_vector == SFTI_VEC_T0 && t1_req))
        else $error("timer1 served ahead of timer0");

    chk_ack_gie_off: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_ack |-> !s_q.gie)
        else $error("global enable left set after acknowledge");

    chk_full_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.full |=> !irq_ack)
        else $error("acknowledge with full stack");

    chk_return_with_irq_reenable_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        (return_with_irq_reenable && !s_q.wr_pend) |=> s_q.gie)
        else $error("return did not re-enable");

    chk_phase_only: assert property (@(posedge hclk) disable iff (!hresetn)
        !phase_two_pulse |=> !irq_ack)
        else $error("acknowledge outside phase two");

    chk_halt_pwrdown: assert property (@(posedge hclk) disable iff (!hresetn)
        halt_instr |=> (s_q.flags[SFTI_PWR_DOWN_BIT] && halted))
        else $error("halt did not set power-down");

    chk_timeout_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        watchdog_timeout |=> s_q.flags[SFTI_EXPIRY_BIT])
        else $error("timeout flag not set");

    chk_bus_keeps_pwr: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.wr_pend && s_q.wr_sel == SFTI_SEL_FLAGS && !halt_instr && !watchdog_timeout
            && !watchdog_clear_instr) |=> (s_q.flags[5:4] == $past(s_q.flags[5:4])))
        else $error("bus write changed power-down or expiry");

    chk_wake_timer: assert property (@(posedge hclk) disable iff (!hresetn)
        (halted && timer0_overflow && !halt_instr) |=> !halted)
        else $error("timer request did not wake");

endmodule

// file: tb/sfti_far_model.sv
module sfti_far_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire0,
    input wire logic fire1,
    output logic phase_two_pulse,
    output logic timer0_overflow,
    output logic timer1_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_q;
    // Four-clock instruction cycle, one sampling pulse each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 2'h0;
            phase_two_pulse <= 1'b0;
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            phase_two_pulse <= (phase_q == 2'h3);
            timer0_overflow <= fire0;
            timer1_overflow <= fire1;
        end
    end
endmodule

// file: tb/tb.sv
module tb import sfti_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // Op nibble, a, b, preset flags, expected flags
    localparam logic [35:0] ALU_T [12] = '{36'h07f01000a, 36'h0ff010007, 36'h10f000102,
        36'h205030003, 36'h280010009, 36'h210100007, 36'h305040007, 36'h400000b0f,
        36'h400010400, 36'h580000405, 36'h601000001, 36'h700000004};
    // Expected ALU result per row
    localparam logic [7:0] ALU_R [12] = '{8'h80, 8'h00, 8'h10, 8'h02, 8'h7f, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    // Pulse mask, expected flags
    localparam logic [15:0] FL_T [4] = '{16'h011f, 16'h043f, 16'h011f, 16'h043f};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    sfti_alu_op_e alu_op = SFTI_OP_ADD;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    logic [7:0] alu_result;
    // Halt, wd clear, wd timeout, call, ret, return_with_irq_reenable, timer0, timer1, alu
    logic [8:0] pulses = 9'h000;
    logic [SFTI_PC_W-1:0] pc_current = 13'h1abc;
    logic [SFTI_PC_W-1:0] return_pc;
    logic phase_two_pulse;
    logic timer0_overflow;
    logic timer1_overflow;
    logic irq_ack;
    logic stack_full;
    logic halted;
    logic [7:0] irq_vector;
    logic [2:0] stack_index;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    sfti_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .alu_valid(pulses[8]), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
        .alu_result(alu_result), .halt_instr(pulses[0]), .watchdog_clear_instr(pulses[1]),
        .watchdog_timeout(pulses[2]), .call_instr(pulses[3]), .return_instr(pulses[4]),
        .return_with_irq_reenable(pulses[5]), .pc_current(pc_current),
        .phase_two_pulse(phase_two_pulse), .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow), .irq_ack(irq_ack), .irq_vector(irq_vector),
        .return_pc(return_pc), .stack_full(stack_full), .stack_index(stack_index),
        .halted(halted));

    sfti_far_model u_far (.hclk(hclk), .hresetn(hresetn), .fire0(pulses[6]),
        .fire1(pulses[7]), .phase_two_pulse(phase_two_pulse),
        .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow));

    initial begin
        forever #4 hclk = ~hclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_addr(input logic [7:0] idx, input logic wr);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
    endtask

    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        bus_addr(idx, 1'b1);
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        bus_addr(idx, 1'b0);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        cmp_val("register", {24'h0, exp}, hrdata);
        cmp_val("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic step(input logic [8:0] m);
        pulses <= m;
        @(posedge hclk);
        pulses <= 9'h000;
        @(posedge hclk);
    endtask

    task automatic wait_ack(input logic want, input logic [7:0] vec);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (n < 10 && !seen) begin
            @(negedge hclk);
            seen = (irq_ack === 1'b1);
            n = n + 1;
        end
        cmp_val("irq_ack", {31'h0, want}, {31'h0, seen});
        if (want) begin
            cmp_val("irq_vector", {24'h0, vec}, {24'h0, irq_vector});
        end
        @(posedge hclk);
    endtask

    initial begin
        logic [35:0] e;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(SFTI_FLAGS_IDX, 8'h00);
        chk_rd(SFTI_IRQC_IDX, 8'h00);
        chk_rd(SFTI_STATE_IDX, 8'h00);
        bus_wr(SFTI_FLAGS_IDX, 8'hff);
        chk_rd(SFTI_FLAGS_IDX, 8'h0f);
        for (int i = 0; i < 4; i++) begin
            step({1'b0, FL_T[i][15:8]});
            chk_rd(SFTI_FLAGS_IDX, FL_T[i][7:0]);
        end
        cmp_val("halted", 32'h0, {31'h0, halted});
        bus_wr(SFTI_FLAGS_IDX, 8'h00);
        chk_rd(SFTI_FLAGS_IDX, 8'h30);
        step(9'h002);
        chk_rd(SFTI_FLAGS_IDX, 8'h00);
        bus_wr(8'h0d, 8'hff);
        chk_rd(8'h0d, 8'h00);
        bus_wr(SFTI_STATE_IDX, 8'hff);
        chk_rd(SFTI_STATE_IDX, 8'h00);
        for (int i = 0; i < 12; i++) begin
            e = ALU_T[i];
            alu_op <= sfti_alu_op_e'(e[34:32]);
            alu_a <= e[31:24];
            alu_b <= e[23:16];
            bus_wr(SFTI_FLAGS_IDX, e[15:8]);
            step(9'h100);
            cmp_val("alu_result", {24'h0, ALU_R[i]}, {24'h0, alu_result});
            chk_rd(SFTI_FLAGS_IDX, e[7:0]);
        end
        bus_wr(SFTI_IRQC_IDX, 8'h0d);
        step(9'h0c0);
        wait_ack(1'b1, SFTI_VEC_T0);
        chk_rd(SFTI_IRQC_IDX, 8'h4c);
        chk_rd(SFTI_STATE_IDX, 8'h01);
        cmp_val("stack_index", 32'h1, {29'h0, stack_index});
        step(9'h020);
        cmp_val("return_pc", 32'h1abc, {19'h0, return_pc});
        wait_ack(1'b1, SFTI_VEC_T1);
        chk_rd(SFTI_IRQC_IDX, 8'h0c);
        step(9'h040);
        wait_ack(1'b0, 8'h00);
        chk_rd(SFTI_IRQC_IDX, 8'h2c);
        bus_wr(SFTI_IRQC_IDX, 8'h2d);
        wait_ack(1'b1, SFTI_VEC_T0);
        chk_rd(SFTI_STATE_IDX, 8'h02);
        step(9'h010);
        step(9'h010);
        chk_rd(SFTI_IRQC_IDX, 8'h0c);
        bus_wr(SFTI_IRQC_IDX, 8'h09);
        step(9'h040);
        wait_ack(1'b0, 8'h00);
        chk_rd(SFTI_IRQC_IDX, 8'h29);
        bus_wr(SFTI_IRQC_IDX, 8'h0d);
        step(9'h001);
        cmp_val("halted", 32'h1, {31'h0, halted});
        step(9'h040);
        wait_ack(1'b1, SFTI_VEC_T0);
        step(9'h010);
        repeat (8) step(9'h008);
        chk_rd(SFTI_STATE_IDX, 8'h08);
        cmp_val("stack_full", 32'h1, {31'h0, stack_full});
        bus_wr(SFTI_IRQC_IDX, 8'h0d);
        step(9'h040);
        wait_ack(1'b0, 8'h00);
        chk_rd(SFTI_IRQC_IDX, 8'h2d);
        step(9'h010);
        wait_ack(1'b1, SFTI_VEC_T0);
        final_report();
    end
endmodule
